// file: inc/xbm_map.vh
/*
 * constants for the expansion bus and memory decode block: register
 * offsets, field positions, reset values, address map and timing.
 * assumes it is included by bare name from the design file only.
 */
//
// Contract
// - bus has 8-bit data, 20 address, 6 irq, 3 dma
// - programmable wait states stretch bus cycles
// - bus clock from cpu clock, half duty
// - free-running video timebase; cards assume no sync
// - refresh strobe drives dack0 line
// - slot eight card-selected line left unsupported
// - i/o decode uses only ten low address bits
// - memory space is twenty bits, one megabyte
// - top 32k goes to boot prom socket
// - next 32k goes to read/write socket one
// - socket two in e segment, jumpered origin
// - c and d segments undecoded on board
// - video area reserved, bank three optional
// - three general regions to dram or bus
`ifndef XBM_MAP_VH
`define XBM_MAP_VH

// ----------------------------------------------------------------
// register word offsets (byte address = 4 x offset)
// ----------------------------------------------------------------
`define XBM_REG_CFG 2'h0
`define XBM_REG_WAIT 2'h1
`define XBM_REG_STAT 2'h2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define XBM_CFG_BANK_LSB 0
`define XBM_CFG_VIDEO_BIT 3
`define XBM_CFG_ORG_LSB 4
`define XBM_WAIT_MEM_LSB 0
`define XBM_WAIT_IO_LSB 4
`define XBM_STAT_REGION_LSB 0
`define XBM_STAT_REFR_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define XBM_CFG_RST 6'h07
`define XBM_WAIT_RST 8'h33

// ----------------------------------------------------------------
// memory map, 20-bit addresses
// ----------------------------------------------------------------
`define XBM_BOOT_BASE 20'hf8000
`define XBM_SOCK1_BASE 20'hf0000
`define XBM_SOCK2_END 20'hf0000
`define XBM_ORG_0 20'he0000
`define XBM_ORG_1 20'he8000
`define XBM_ORG_2 20'hec000
`define XBM_ORG_3 20'hee000
`define XBM_FREE_BASE 20'hc0000
`define XBM_VIDEO_BASE 20'ha0000
`define XBM_BANK3_BASE 20'h80000
`define XBM_BANK2_BASE 20'h40000

// on-board i/o ports occupy the low system range
`define XBM_IO_ONBOARD_END 10'h100

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define XBM_SYS_CLK_HZ 10000000
`define XBM_OSC_HZ 14318180
`define XBM_NCO_BITS 24

`endif

// file: hdl/xbm_top.v
/*
 * expansion bus interface and system address decoder: takes cpu
 * memory and i/o cycles, steers them to on-board selects or to the
 * expansion connector, brings out bus clocks, refresh and dma lines,
 * and holds its settings behind an avalon-mm slave.
 * assumes cpu signals are on i_sys_clk; connector inputs are not.
 */
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`include "xbm_map.vh"

module xbm_top #(
   parameter MEM_BITS = 20,
   parameter IO_BITS = 16,
   parameter IRQ_NUM = 6,
   parameter DMA_NUM = 3
) (
   // clock and reset
   input wire i_sys_clk,
   input wire i_rst,
   // avalon-mm register slave
   input wire [1:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // cpu cycle request
   input wire [MEM_BITS-1:0] i_cpu_addr,
   input wire i_cpu_mem_rd,
   input wire i_cpu_mem_wr,
   input wire i_cpu_io_rd,
   input wire i_cpu_io_wr,
   input wire [7:0] i_cpu_wdata,
   output reg [7:0] o_cpu_rdata,
   output reg o_cpu_ready,
   // cpu refresh, dma and interrupt side
   input wire i_cpu_refresh,
   input wire [DMA_NUM-1:0] i_cpu_dack,
   output reg [DMA_NUM-1:0] o_cpu_drq,
   output reg [IRQ_NUM-1:0] o_cpu_irq,
   // on-board chip selects
   output reg o_boot_prom_socket_sel,
   output reg o_bytewide_socket_one_sel,
   output reg o_bytewide_socket_two_sel,
   output reg o_dram_bank_one_sel,
   output reg o_dram_bank_two_sel,
   output reg o_dram_bank_three_sel,
   output reg o_onboard_io_sel,
   // expansion connector
   output reg [MEM_BITS-1:0] o_xb_addr,
   input wire [7:0] i_xb_data,
   output reg [7:0] o_xb_data,
   output reg o_xb_data_oe,
   output reg o_xb_memr_n,
   output reg o_xb_memw_n,
   output reg o_xb_ior_n,
   output reg o_xb_iow_n,
   output reg o_xb_ale,
   input wire [IRQ_NUM-1:0] i_xb_irq,
   input wire [DMA_NUM-1:0] i_xb_drq,
   output reg [DMA_NUM:0] o_xb_dack_n,
   output reg o_xb_clock,
   output reg o_video_timebase_out
);

   // ----------------------------------------------------------------
   // region codes and cycle states
   // ----------------------------------------------------------------
   localparam [2:0] RG_BUS = 3'h0;
   localparam [2:0] RG_BOOT = 3'h1;
   localparam [2:0] RG_SOCK1 = 3'h2;
   localparam [2:0] RG_SOCK2 = 3'h3;
   localparam [2:0] RG_BANK1 = 3'h4;
   localparam [2:0] RG_BANK2 = 3'h5;
   localparam [2:0] RG_BANK3 = 3'h6;
   localparam [2:0] RG_IO = 3'h7;

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   // nco step giving the timebase average rate from the system clock
   localparam integer NCO_W = `XBM_NCO_BITS;
   localparam [63:0] NCO_FULL =
      ((64'd1 << NCO_W) * `XBM_OSC_HZ) / `XBM_SYS_CLK_HZ;
   localparam [NCO_W:0] NCO_STEP = NCO_FULL[NCO_W:0];

   // ----------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------
   function [19:0] sock2_origin;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: sock2_origin = `XBM_ORG_0;
            2'h1: sock2_origin = `XBM_ORG_1;
            2'h2: sock2_origin = `XBM_ORG_2;
            default: sock2_origin = `XBM_ORG_3;
         endcase
      end
   endfunction

   // jumpers: bank bit high keeps the region on board
   function [2:0] mem_region;
      input [19:0] a;
      input [2:0] bank_on;
      input video_bank3;
      input [1:0] org;
      begin
         if (a >= `XBM_BOOT_BASE)
            mem_region = RG_BOOT;
         else if (a >= `XBM_SOCK1_BASE)
            mem_region = RG_SOCK1;
         else if (a >= sock2_origin(org))
            mem_region = RG_SOCK2;
         else if (a >= `XBM_FREE_BASE)
            mem_region = RG_BUS;
         else if (a >= `XBM_VIDEO_BASE)
            mem_region = video_bank3 ? RG_BANK3 : RG_BUS;
         else if (a >= `XBM_BANK3_BASE)
            mem_region = bank_on[2] ? RG_BANK3 : RG_BUS;
         else if (a >= `XBM_BANK2_BASE)
            mem_region = bank_on[1] ? RG_BANK2 : RG_BUS;
         else
            mem_region = bank_on[0] ? RG_BANK1 : RG_BUS;
      end
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg [5:0] cfg_ff;
   reg [7:0] wait_ff;
   reg [2:0] last_region_ff;
   reg [7:0] refr_cnt_ff;
   reg avs_done_ff;
   wire avs_req = i_avs_read | i_avs_write;
   wire avs_take = avs_req & ~o_avs_waitrequest;
   // one wait cycle per access, then release for one cycle
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_avs_waitrequest <= 1'b1;
         avs_done_ff <= 1'b0;
         o_avs_readdata <= 32'h0;
         cfg_ff <= `XBM_CFG_RST;
         wait_ff <= `XBM_WAIT_RST;
      end else begin
         o_avs_waitrequest <= ~(avs_req & ~avs_done_ff);
         avs_done_ff <= avs_req & ~avs_done_ff;
         if (avs_req & ~avs_done_ff) begin
            case (i_avs_address)
               `XBM_REG_CFG: o_avs_readdata <= {26'h0, cfg_ff};
               `XBM_REG_WAIT: o_avs_readdata <= {24'h0, wait_ff};
               `XBM_REG_STAT: o_avs_readdata <=
                  {16'h0, refr_cnt_ff, 5'h0, last_region_ff};
               default: o_avs_readdata <= 32'h0;
            endcase
         end
         if (avs_take & i_avs_write) begin
            case (i_avs_address)
               `XBM_REG_CFG: cfg_ff <= i_avs_writedata[5:0];
               `XBM_REG_WAIT: wait_ff <= i_avs_writedata[7:0];
               default: ;
            endcase
         end
      end
   end

   wire [2:0] bank_on = cfg_ff[`XBM_CFG_BANK_LSB +: 3];
   wire video_bank3 = cfg_ff[`XBM_CFG_VIDEO_BIT];
   wire [1:0] sock2_org = cfg_ff[`XBM_CFG_ORG_LSB +: 2];
   wire [3:0] mem_ws = wait_ff[`XBM_WAIT_MEM_LSB +: 4];
   wire [3:0] io_ws = wait_ff[`XBM_WAIT_IO_LSB +: 4];

   // ----------------------------------------------------------------
   // cycle decode and sequencing
   // ----------------------------------------------------------------
   wire cpu_io = i_cpu_io_rd | i_cpu_io_wr;
   wire cpu_req = i_cpu_mem_rd | i_cpu_mem_wr | cpu_io;
   wire cpu_rd = i_cpu_mem_rd | i_cpu_io_rd;
   // upper i/o address bits never take part in port selection
   wire [9:0] io_port = i_cpu_addr[9:0];
   wire io_onboard = io_port < `XBM_IO_ONBOARD_END;
   reg [2:0] region;
   always @* begin
      if (cpu_io)
         region = io_onboard ? RG_IO : RG_BUS;
      else
         region = mem_region(i_cpu_addr, bank_on, video_bank3,
            sock2_org);
   end
   reg [2:0] state_ff;
   reg [3:0] ws_cnt_ff;
   reg [2:0] cyc_region_ff;
   reg cyc_rd_ff;
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_ff <= ST_IDLE;
         ws_cnt_ff <= 4'h0;
         cyc_region_ff <= RG_BUS;
         cyc_rd_ff <= 1'b0;
         last_region_ff <= RG_BUS;
         o_cpu_ready <= 1'b0;
         o_cpu_rdata <= 8'h0;
         o_xb_addr <= 20'h0;
         o_xb_data <= 8'h0;
         o_xb_data_oe <= 1'b0;
         o_xb_memr_n <= 1'b1;
         o_xb_memw_n <= 1'b1;
         o_xb_ior_n <= 1'b1;
         o_xb_iow_n <= 1'b1;
         o_xb_ale <= 1'b0;
         o_boot_prom_socket_sel <= 1'b0;
         o_bytewide_socket_one_sel <= 1'b0;
         o_bytewide_socket_two_sel <= 1'b0;
         o_dram_bank_one_sel <= 1'b0;
         o_dram_bank_two_sel <= 1'b0;
         o_dram_bank_three_sel <= 1'b0;
         o_onboard_io_sel <= 1'b0;
      end else begin
         o_cpu_ready <= 1'b0;
         o_xb_ale <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (cpu_req) begin
                  state_ff <= ST_WAIT;
                  cyc_region_ff <= region;
                  last_region_ff <= region;
                  cyc_rd_ff <= cpu_rd;
                  ws_cnt_ff <= cpu_io ? io_ws : mem_ws;
                  o_boot_prom_socket_sel <= region == RG_BOOT;
                  o_bytewide_socket_one_sel <= region == RG_SOCK1;
                  o_bytewide_socket_two_sel <= region == RG_SOCK2;
                  o_dram_bank_one_sel <= region == RG_BANK1;
                  o_dram_bank_two_sel <= region == RG_BANK2;
                  o_dram_bank_three_sel <= region == RG_BANK3;
                  o_onboard_io_sel <= region == RG_IO;
                  if (region == RG_BUS) begin
                     o_xb_addr <= i_cpu_addr;
                     o_xb_ale <= 1'b1;
                     o_xb_data <= i_cpu_wdata;
                     // buffer turns toward the cpu on reads
                     o_xb_data_oe <= ~cpu_rd;
                     o_xb_memr_n <= ~i_cpu_mem_rd;
                     o_xb_memw_n <= ~i_cpu_mem_wr;
                     o_xb_ior_n <= ~i_cpu_io_rd;
                     o_xb_iow_n <= ~i_cpu_io_wr;
                  end
               end
            end
            ST_WAIT: begin
               if (ws_cnt_ff == 4'h0) begin
                  state_ff <= ST_DONE;
                  o_cpu_ready <= 1'b1;
                  // bus read data taken on the last stretched cycle
                  if (cyc_region_ff == RG_BUS && cyc_rd_ff)
                     o_cpu_rdata <= i_xb_data;
               end else begin
                  ws_cnt_ff <= ws_cnt_ff - 4'h1;
               end
            end
            ST_DONE: begin
               // strobes drop here, cpu must lower its request
               state_ff <= ST_IDLE;
               o_xb_data_oe <= 1'b0;
               o_xb_memr_n <= 1'b1;
               o_xb_memw_n <= 1'b1;
               o_xb_ior_n <= 1'b1;
               o_xb_iow_n <= 1'b1;
               o_boot_prom_socket_sel <= 1'b0;
               o_bytewide_socket_one_sel <= 1'b0;
               o_bytewide_socket_two_sel <= 1'b0;
               o_dram_bank_one_sel <= 1'b0;
               o_dram_bank_two_sel <= 1'b0;
               o_dram_bank_three_sel <= 1'b0;
               o_onboard_io_sel <= 1'b0;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // connector inputs: two flops, data bus sampled only at cycle end
   // ----------------------------------------------------------------
   reg [IRQ_NUM-1:0] irq_s1_ff;
   reg [DMA_NUM-1:0] drq_s1_ff;
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         irq_s1_ff <= {IRQ_NUM{1'b0}};
         drq_s1_ff <= {DMA_NUM{1'b0}};
         o_cpu_irq <= {IRQ_NUM{1'b0}};
         o_cpu_drq <= {DMA_NUM{1'b0}};
      end else begin
         irq_s1_ff <= i_xb_irq;
         drq_s1_ff <= i_xb_drq;
         o_cpu_irq <= irq_s1_ff;
         o_cpu_drq <= drq_s1_ff;
      end
   end

   // ----------------------------------------------------------------
   // refresh and dack lines; no slot-eight card-selected port at all
   // ----------------------------------------------------------------
   reg refr_d_ff;
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_xb_dack_n <= {(DMA_NUM+1){1'b1}};
         refr_d_ff <= 1'b0;
         refr_cnt_ff <= 8'h0;
      end else begin
         // bursts pass straight through, no spacing enforced
         o_xb_dack_n <= ~{i_cpu_dack, i_cpu_refresh};
         refr_d_ff <= i_cpu_refresh;
         if (i_cpu_refresh & ~refr_d_ff)
            refr_cnt_ff <= refr_cnt_ff + 8'h1;
      end
   end

   // ----------------------------------------------------------------
   // bus clocks
   // ----------------------------------------------------------------
   reg [NCO_W-1:0] nco_ff;
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_xb_clock <= 1'b0;
         nco_ff <= {NCO_W{1'b0}};
         o_video_timebase_out <= 1'b0;
      end else begin
         // toggling every rising edge gives an even duty cycle
         o_xb_clock <= ~o_xb_clock;
         // free-running accumulator, never reset by bus activity
         nco_ff <= nco_ff + NCO_STEP[NCO_W-1:0];
         o_video_timebase_out <= nco_ff[NCO_W-1];
      end
   end

endmodule

// file: bench/xbm_checker.sv
/* assertions for the expansion bus block, bound to its top module.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module xbm_checker #(
   parameter MEM_BITS = 20,
   parameter DMA_NUM = 3
) (
   // watched ports
   input wire i_sys_clk,
   input wire i_rst,
   input wire [MEM_BITS-1:0] i_cpu_addr,
   input wire i_cpu_refresh,
   input wire [DMA_NUM-1:0] i_cpu_dack,
   input wire o_cpu_ready,
   input wire o_boot_prom_socket_sel,
   input wire o_bytewide_socket_one_sel,
   input wire o_bytewide_socket_two_sel,
   input wire o_dram_bank_one_sel,
   input wire o_dram_bank_two_sel,
   input wire o_dram_bank_three_sel,
   input wire o_onboard_io_sel,
   input wire o_xb_data_oe,
   input wire o_xb_memr_n,
   input wire o_xb_memw_n,
   input wire o_xb_ior_n,
   input wire o_xb_iow_n,
   input wire o_xb_ale,
   input wire [DMA_NUM:0] o_xb_dack_n,
   input wire o_xb_clock
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   clk_toggle_a: assert property (
      !$past(i_rst) && !$past(i_rst, 2) |-> o_xb_clock != $past(o_xb_clock))
      else $error("bus clock did not toggle");
   refresh_ack_a: assert property (
      !$past(i_rst) |-> o_xb_dack_n[0] == !$past(i_cpu_refresh))
      else $error("refresh not on dack0");
   dma_ack_a: assert property (
      !$past(i_rst) |-> o_xb_dack_n[DMA_NUM:1] == ~$past(i_cpu_dack))
      else $error("dma ack not passed");
   ready_pulse_a: assert property (
      o_cpu_ready |=> !o_cpu_ready)
      else $error("ready longer than one cycle");
   read_dir_a: assert property (
      !o_xb_memr_n || !o_xb_ior_n |-> !o_xb_data_oe)
      else $error("buffer driven during bus read");
   write_dir_a: assert property (
      !o_xb_memw_n || !o_xb_iow_n |-> o_xb_data_oe)
      else $error("buffer not driven during bus write");
   bus_ale_a: assert property (
      $fell(o_xb_memr_n) |-> o_xb_ale ##1 !o_xb_ale)
      else $error("no single ale at bus cycle");
   boot_area_a: assert property (
      $rose(o_boot_prom_socket_sel) |-> $past(i_cpu_addr[19:15]) == 5'h1f)
      else $error("boot select outside top area");
   sock_one_a: assert property (
      $rose(o_bytewide_socket_one_sel) |-> $past(i_cpu_addr[19:15]) == 5'h1e)
      else $error("socket one select outside its area");
   bank_one_a: assert property (
      $rose(o_dram_bank_one_sel) |-> $past(i_cpu_addr[19:18]) == 2'h0)
      else $error("bank one select outside its area");
   sel_onehot_a: assert property (
      $onehot0({o_onboard_io_sel, o_dram_bank_three_sel, o_dram_bank_two_sel,
      o_dram_bank_one_sel, o_bytewide_socket_two_sel,
      o_bytewide_socket_one_sel, o_boot_prom_socket_sel}))
      else $error("more than one select");
   io_low_a: assert property (
      $rose(o_onboard_io_sel) |-> $past(i_cpu_addr[9:8]) == 2'h0)
      else $error("on-board io select for high port");
endmodule
bind xbm_top xbm_checker #(.MEM_BITS(MEM_BITS), .DMA_NUM(DMA_NUM)) i_chk (
   .i_sys_clk, .i_rst, .i_cpu_addr, .i_cpu_refresh, .i_cpu_dack,
   .o_cpu_ready, .o_boot_prom_socket_sel, .o_bytewide_socket_one_sel,
   .o_bytewide_socket_two_sel, .o_dram_bank_one_sel, .o_dram_bank_two_sel,
   .o_dram_bank_three_sel, .o_onboard_io_sel, .o_xb_data_oe, .o_xb_memr_n,
   .o_xb_ior_n, .o_xb_ale, .o_xb_dack_n, .o_xb_clock, .o_xb_memw_n,
   .o_xb_iow_n
);

// file: bench/xbm_card_model.sv
/* behavioural 8-bit expansion card on the connector.
   assumes active-low strobes and a registered address from the block. */
`timescale 1ns/1ns
module xbm_card_model (
   // connector side
   input wire i_sys_clk,
   input wire [19:0] i_addr,
   input wire i_memr_n,
   input wire i_ior_n,
   input wire i_refr_n,
   input wire [5:0] i_irq_req,
   input wire [2:0] i_drq_req,
   output wire [7:0] o_data,
   output wire [5:0] o_irq,
   output wire [2:0] o_drq
);
   reg [7:0] idle_ff = 8'h00;
   reg [7:0] refr_ff = 8'h00;
   // ports 000-0ff belong to the board, so the card never answers there
   wire io_hit = !i_ior_n && (i_addr[9:8] != 2'h0);
   // released bus shows a changing pattern, not the last byte
   always @(posedge i_sys_clk) begin
      idle_ff <= ~idle_ff;
   end
   // refresh is only counted, never used as a time base
   always @(posedge i_sys_clk) begin
      if (!i_refr_n) begin
         refr_ff <= refr_ff + 8'h01;
      end
   end
   assign o_data = (!i_memr_n || io_hit) ? (i_addr[7:0] ^ 8'h5a) : idle_ff;
   assign o_irq = i_irq_req;
   assign o_drq = i_drq_req;
endmodule

// file: bench/testbench.sv
/* self-checking bench for the expansion bus block.
   assumes the card model and the bound checker. */
`timescale 1ns/1ns
module testbench;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [1:0] aaddr = 2'h0;
   reg ard = 1'b0;
   reg awr = 1'b0;
   reg [31:0] awd = 32'h0;
   reg [19:0] caddr = 20'h0;
   reg [3:0] cstb = 4'h0;
   reg [7:0] cwd = 8'h00;
   reg refr = 1'b0;
   reg [2:0] dack = 3'h0;
   reg [5:0] irq_req = 6'h00;
   reg [2:0] drq_req = 3'h0;
   wire [31:0] ard_data;
   wire wreq, rdy, oe, memr_n, ior_n, bclk, tbase;
   wire [7:0] crd, xdo, xdi;
   wire [6:0] sels;
   wire [19:0] xaddr;
   wire [5:0] irq_c, irq_x;
   wire [2:0] drq_c, drq_x;
   wire [3:0] dack_n;
   integer failures = 0;
   integer total_checks = 0;
   // {cfg, address, region code}
   function [28:0] tbl(input integer i);
      case (i)
         0: tbl = {6'h07, 20'hffff0, 3'h1};
         1: tbl = {6'h07, 20'hf7fff, 3'h2};
         2: tbl = {6'h07, 20'he0000, 3'h3};
         3: tbl = {6'h07, 20'hdffff, 3'h0};
         4: tbl = {6'h07, 20'ha0000, 3'h0};
         5: tbl = {6'h07, 20'h3ffff, 3'h4};
         6: tbl = {6'h07, 20'h40000, 3'h5};
         7: tbl = {6'h07, 20'h9ffff, 3'h6};
         8: tbl = {6'h3f, 20'hbffff, 3'h6};
         9: tbl = {6'h3f, 20'hedfff, 3'h0};
         10: tbl = {6'h3f, 20'hee000, 3'h3};
         11: tbl = {6'h10, 20'h00000, 3'h0};
         12: tbl = {6'h10, 20'h7ffff, 3'h0};
         13: tbl = {6'h10, 20'h9ffff, 3'h0};
         14: tbl = {6'h10, 20'he7fff, 3'h0};
         15: tbl = {6'h10, 20'he8000, 3'h3};
         16: tbl = {6'h20, 20'hec000, 3'h3};
         default: tbl = {6'h20, 20'hebfff, 3'h0};
      endcase
   endfunction
   always #50 clk = ~clk;
   xbm_top i_dut (
      .i_sys_clk(clk), .i_rst(rst),
      .i_avs_address(aaddr), .i_avs_read(ard), .i_avs_write(awr),
      .i_avs_writedata(awd), .o_avs_readdata(ard_data),
      .o_avs_waitrequest(wreq),
      .i_cpu_addr(caddr), .i_cpu_mem_rd(cstb[0]), .i_cpu_mem_wr(cstb[1]),
      .i_cpu_io_rd(cstb[2]), .i_cpu_io_wr(cstb[3]), .i_cpu_wdata(cwd),
      .o_cpu_rdata(crd), .o_cpu_ready(rdy), .i_cpu_refresh(refr),
      .i_cpu_dack(dack), .o_cpu_drq(drq_c), .o_cpu_irq(irq_c),
      .o_boot_prom_socket_sel(sels[0]), .o_bytewide_socket_one_sel(sels[1]),
      .o_bytewide_socket_two_sel(sels[2]), .o_dram_bank_one_sel(sels[3]),
      .o_dram_bank_two_sel(sels[4]), .o_dram_bank_three_sel(sels[5]),
      .o_onboard_io_sel(sels[6]), .o_xb_addr(xaddr), .i_xb_data(xdi),
      .o_xb_data(xdo), .o_xb_data_oe(oe), .o_xb_memr_n(memr_n),
      .o_xb_memw_n(), .o_xb_ior_n(ior_n), .o_xb_iow_n(), .o_xb_ale(),
      .i_xb_irq(irq_x), .i_xb_drq(drq_x), .o_xb_dack_n(dack_n),
      .o_xb_clock(bclk), .o_video_timebase_out(tbase));
   xbm_card_model i_card (
      .i_sys_clk(clk), .i_addr(xaddr), .i_memr_n(memr_n), .i_ior_n(ior_n),
      .i_refr_n(dack_n[0]), .i_irq_req(irq_req), .i_drq_req(drq_req),
      .o_data(xdi), .o_irq(irq_x), .o_drq(drq_x));
   task chk(input string name, input [31:0] seen, input [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   // slave answer time is not assumed; the loop has no bound, only the 20000-cycle watchdog cuts a hang
   task avs(input w, input [1:0] a, input [31:0] d, output [31:0] q);
      @(posedge clk);
      ard <= !w;
      awr <= w;
      aaddr <= a;
      awd <= d;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = ard_data;
      ard <= 1'b0;
      awr <= 1'b0;
   endtask
   task cpu(input [3:0] k, input [19:0] a, input [7:0] d,
      output [7:0] q, output integer n, output [7:0] s);
      @(posedge clk);
      cstb <= k;
      caddr <= a;
      cwd <= d;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (rdy !== 1'b1);
      q = crd;
      s = {oe, sels};
      cstb <= 4'h0;
   endtask
   task t_regs;
      reg [31:0] q;
      reg [7:0] r, s;
      integer n;
      avs(1'b0, 2'h0, 32'h0, q);
      chk("cfg reset", q, 32'h7);
      avs(1'b0, 2'h1, 32'h0, q);
      chk("wait reset", q, 32'h33);
      avs(1'b1, 2'h3, 32'hff, q);
      avs(1'b0, 2'h3, 32'h0, q);
      chk("unmapped read", q, 32'h0);
      cpu(4'h1, 20'hf8000, 8'h00, r, n, s);
      chk("ready with 3 waits", n, 6);
      avs(1'b1, 2'h1, 32'h0, q);
      $display("register test done");
   endtask
   task t_map;
      reg [31:0] q;
      reg [7:0] r, s;
      reg [2:0] c;
      reg [28:0] e;
      integer i, n;
      for (i = 0; i < 18; i = i + 1) begin
         e = tbl(i);
         c = e[2:0];
         avs(1'b1, 2'h0, {26'h0, e[28:23]}, q);
         cpu(4'h1, e[22:3], 8'h00, r, n, s);
         avs(1'b0, 2'h2, 32'h0, q);
         chk("region", q[2:0], c);
         chk("selects", s[6:0], (c == 3'h0) ? 7'h0 : 7'h1 << (c - 3'h1));
      end
      $display("map test done");
   endtask
   task t_io;
      reg [31:0] q;
      reg [7:0] r, s;
      integer n;
      avs(1'b1, 2'h1, 32'h50, q);
      cpu(4'h4, 20'h00060, 8'h00, r, n, s);
      chk("io wait count", n, 8);
      chk("onboard io", s[6], 1);
      cpu(4'h4, 20'h0fc60, 8'h00, r, n, s);
      chk("upper io bits ignored", s[6], 1);
      cpu(4'h4, 20'h00300, 8'h00, r, n, s);
      chk("bus io data", r, 8'h5a);
      cpu(4'h1, 20'hc0012, 8'h00, r, n, s);
      chk("mem wait count", n, 3);
      chk("bus mem data", r, 8'h48);
      cpu(4'h2, 20'hc0034, 8'ha5, r, n, s);
      chk("write drives bus", s[7], 1);
      chk("bus write data", xdo, 8'ha5);
      $display("io and bus test done");
   endtask
   task t_lines;
      reg lr;
      reg [2:0] ld;
      integer i, bt, tt;
      reg pb, pt;
      @(posedge clk);
      lr = refr;
      ld = dack;
      bt = 0;
      tt = 0;
      pb = bclk;
      pt = tbase;
      // toggling every cycle gives strobes 200 ns apart
      for (i = 0; i < 20; i = i + 1) begin
         @(posedge clk);
         chk("refresh line", dack_n[0], !lr);
         chk("dma ack", dack_n[3:1], {29'h0, ~ld});
         if (bclk !== pb) bt = bt + 1;
         if (tbase !== pt) tt = tt + 1;
         pb = bclk;
         pt = tbase;
         lr = refr;
         ld = dack;
         refr <= ~refr;
         dack <= dack + 3'h1;
      end
      chk("bus clock toggles", bt, 20);
      chk("timebase runs", tt != 0, 1);
      irq_req <= 6'h2a;
      drq_req <= 3'h5;
      repeat (5) @(posedge clk);
      chk("irq levels", irq_c, 6'h2a);
      chk("dma requests", drq_c, 3'h5);
      $display("line test done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures = failures + 1;
      end_of_test;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_map;
      t_io;
      t_lines;
      end_of_test;
   end
endmodule
